// File: hw/sfz_cfg.svh
// Purpose: constants for the scroll/fade/zoom command controller
// Assumes: 20 MHz clock, byte-wide command port toward the display device
// Notes:   opcodes and byte counts of the device command set
`ifndef SFZ_CFG_SVH
`define SFZ_CFG_SVH
`define SFZ_OP_HSCROLL_R   8'h26
`define SFZ_OP_HSCROLL_L   8'h27
`define SFZ_OP_VHSCROLL_R  8'h29
`define SFZ_OP_VHSCROLL_L  8'h2A
`define SFZ_OP_CSCROLL_R   8'h2C
`define SFZ_OP_CSCROLL_L   8'h2D
`define SFZ_OP_SCROLL_OFF  8'h2E
`define SFZ_OP_SCROLL_ON   8'h2F
`define SFZ_OP_VAREA       8'hA3
`define SFZ_OP_FADE        8'h23
`define SFZ_OP_ZOOM        8'hD6
`define SFZ_OP_COMCFG      8'hDA
`define SFZ_OP_ADDRMODE    8'h20
`define SFZ_OP_COLRANGE    8'h21
`define SFZ_OP_PAGERANGE   8'h22
`define SFZ_OP_PAGESEL     8'hB0
`define SFZ_OP_COLHI       8'h10
`define SFZ_OP_COLLO       8'h00
`define SFZ_AM_VERT        8'h01
`define SFZ_AM_PAGE        8'h02
`define SFZ_DUMMY0         8'h00
`define SFZ_DUMMY1         8'h01
`define SFZ_FULL_COL_LO    8'h00
`define SFZ_FULL_COL_HI    8'h7F
`define SFZ_COMCFG_ALT     8'h12
`define SFZ_VH_LEN         4'h8
`define SFZ_CS_LEN         4'h7
`define SFZ_VA_LEN         4'h3
`define SFZ_FRAME_NS       10000000
`define SFZ_CLK_NS         50
`define SFZ_FRAMES_GAP     2
`endif

// File: hw/sfz_pkg.sv
// Purpose: types for the scroll/fade/zoom command controller
// Assumes: used together with sfz_cfg.svh
// Notes:   user orders and byte-port carrier
package sfz_pkg;
    typedef enum logic [3:0] {
        SFZ_CMD_DIAG    = 4'h0,
        SFZ_CMD_STOP    = 4'h1,
        SFZ_CMD_START   = 4'h2,
        SFZ_CMD_VAREA   = 4'h3,
        SFZ_CMD_CSTEP   = 4'h4,
        SFZ_CMD_FADE    = 4'h5,
        SFZ_CMD_ZOOM    = 4'h6,
        SFZ_CMD_WRCOL   = 4'h7
    } sfz_cmd_t;
    typedef struct packed {
        sfz_cmd_t   cmd;
        logic       left;
        logic [2:0] page_s;
        logic [2:0] page_e;
        logic [6:0] col_s;
        logic [6:0] col_e;
        logic [2:0] speed;
        logic       hoff;
        logic [5:0] voff;
        logic [7:0] arg;
        logic       vert_mode;
    } sfz_req_t;
    typedef struct packed {
        logic       valid;
        logic       dc;
        logic [7:0] data;
    } sfz_byte_t;
endpackage : sfz_pkg

// File: hw/sfz_ctrl.sv
// Purpose: host-side sequencer that emits scroll, fade and zoom command byte strings
// Assumes: device takes one byte per accepted beat (byte_ready), dc low = command
// Notes:   frame gap is a parameter so simulation can shorten it
`timescale 1ns/1ns
`include "sfz_cfg.svh"
module sfz_ctrl
    import sfz_pkg::*;
#(
    parameter int GAP_CYCLES = (`SFZ_FRAMES_GAP * `SFZ_FRAME_NS) / `SFZ_CLK_NS,
    parameter int MUX_RATIO  = 64
) (
    input  wire logic      clk,
    input  wire logic      reset,
    input  wire sfz_req_t  req,
    input  wire logic      req_valid,
    output logic           req_ready,
    output logic           req_error,
    input  wire logic      ram_valid,
    input  wire logic [7:0] ram_data,
    output logic           ram_ready,
    output logic           ram_done,
    output logic           byte_valid,
    output logic           byte_dc,
    output logic [7:0]     byte_data,
    input  wire logic      byte_ready,
    output logic           scroll_active,
    output logic           need_rewrite
);
    typedef enum logic [4:0] {
        SFZ_IDLE = 5'b00001,
        SFZ_SEND = 5'b00010,
        SFZ_DATA = 5'b00100,
        SFZ_WAIT = 5'b01000,
        SFZ_ERR  = 5'b10000
    } sfz_st_t;

    sfz_st_t    state_q;
    sfz_req_t   req_q;
    logic [7:0] seq_q [0:15];
    logic [3:0] len_q;
    logic [3:0] idx_q;
    logic       setup_ok_q;
    logic       zoom_ok_q;
    logic [31:0] gap_q;
    logic       gap_pend_q;
    logic [7:0] ram_cnt_q;
    logic [7:0] ram_len;
    logic       accept;
    logic       bad;
    logic       beat;

    assign beat   = byte_valid && byte_ready;
    assign accept = req_valid && req_ready;
    // pages covered by a column rewrite, one RAM byte per page
    assign ram_len = 8'({5'h00, req_q.page_e} - {5'h00, req_q.page_s} + 8'h01);

    // legality: refuse orders that would corrupt RAM or run ahead of setup
    always_comb begin
        bad = 1'b0;
        case (req.cmd)
            SFZ_CMD_START: bad = !setup_ok_q;
            SFZ_CMD_CSTEP: bad = scroll_active || gap_pend_q;
            SFZ_CMD_WRCOL: bad = scroll_active;
            SFZ_CMD_ZOOM:  bad = !zoom_ok_q && req.arg[0];
            SFZ_CMD_VAREA: bad = (32'(req.arg[6:0]) > MUX_RATIO);
            default:       bad = 1'b0;
        endcase
    end

    // byte string builder and sequencer
    always_ff @(posedge clk) begin
        if (reset) begin
            state_q   <= SFZ_IDLE;
            req_ready <= 1'b1;
            req_error <= 1'b0;
            len_q     <= 4'h0;
            idx_q     <= 4'h0;
            req_q     <= '0;
            byte_valid <= 1'b0;
            byte_dc   <= 1'b0;
            byte_data <= 8'h00;
        end else begin
            req_error <= 1'b0;
            case (state_q)
                SFZ_IDLE: begin
                    if (accept && bad) begin
                        req_error <= 1'b1;
                    end else if (accept) begin
                        req_q     <= req;
                        req_ready <= 1'b0;
                        idx_q     <= 4'h0;
                        state_q   <= SFZ_SEND;
                        case (req.cmd)
                            SFZ_CMD_DIAG: begin
                                // stop first, then 8-byte setup
                                seq_q[0] <= `SFZ_OP_SCROLL_OFF;
                                seq_q[1] <= req.left ? `SFZ_OP_VHSCROLL_L
                                                     : `SFZ_OP_VHSCROLL_R;
                                seq_q[2] <= {7'h00, req.hoff};   // 0: vertical only
                                seq_q[3] <= {5'h00, req.page_s};
                                seq_q[4] <= {5'h00, req.speed};
                                seq_q[5] <= {5'h00, req.page_e};
                                seq_q[6] <= {2'h0, req.voff};    // 0: horizontal only
                                // full width when the end bound is zero
                                seq_q[7] <= (req.col_e == 7'h00) ? `SFZ_FULL_COL_LO
                                                                 : {1'b0, req.col_s};
                                seq_q[8] <= (req.col_e == 7'h00) ? `SFZ_FULL_COL_HI
                                                                 : {1'b0, req.col_e};
                                len_q <= 4'(`SFZ_VH_LEN + 4'h1);
                            end
                            SFZ_CMD_STOP: begin
                                seq_q[0] <= `SFZ_OP_SCROLL_OFF;
                                len_q    <= 4'h1;
                            end
                            SFZ_CMD_START: begin
                                seq_q[0] <= `SFZ_OP_SCROLL_ON;
                                len_q    <= 4'h1;
                            end
                            SFZ_CMD_VAREA: begin
                                seq_q[0] <= `SFZ_OP_VAREA;
                                seq_q[1] <= {2'h0, req.voff};
                                seq_q[2] <= {1'b0, req.arg[6:0]};
                                len_q    <= `SFZ_VA_LEN;
                            end
                            SFZ_CMD_CSTEP: begin
                                seq_q[0] <= req.left ? `SFZ_OP_CSCROLL_L
                                                     : `SFZ_OP_CSCROLL_R;
                                seq_q[1] <= `SFZ_DUMMY0;
                                seq_q[2] <= {5'h00, req.page_s};
                                seq_q[3] <= `SFZ_DUMMY1;
                                seq_q[4] <= {5'h00, req.page_e};
                                seq_q[5] <= {1'b0, req.col_s};
                                seq_q[6] <= {1'b0, req.col_e};
                                len_q    <= `SFZ_CS_LEN;
                            end
                            SFZ_CMD_FADE: begin
                                seq_q[0] <= `SFZ_OP_FADE;
                                seq_q[1] <= req.arg;
                                len_q    <= 4'h2;
                            end
                            SFZ_CMD_ZOOM: begin
                                seq_q[0] <= `SFZ_OP_ZOOM;
                                seq_q[1] <= {7'h00, req.arg[0]};
                                len_q    <= 4'h2;
                            end
                            SFZ_CMD_WRCOL: begin
                                seq_q[0] <= `SFZ_OP_ADDRMODE;
                                seq_q[1] <= req.vert_mode ? `SFZ_AM_VERT : `SFZ_AM_PAGE;
                                if (req.vert_mode) begin
                                    seq_q[2] <= `SFZ_OP_COLRANGE;
                                    seq_q[3] <= {1'b0, req.col_s};
                                    seq_q[4] <= {1'b0, req.col_s};
                                    seq_q[5] <= `SFZ_OP_PAGERANGE;
                                    seq_q[6] <= {5'h00, req.page_s};
                                    seq_q[7] <= {5'h00, req.page_e};
                                    len_q    <= 4'h8;
                                end else begin
                                    // one page per pass, start page only
                                    seq_q[2] <= `SFZ_OP_PAGESEL | {5'h00, req.page_s};
                                    seq_q[3] <= `SFZ_OP_COLHI | {5'h00, req.col_s[6:4]};
                                    seq_q[4] <= `SFZ_OP_COLLO | {4'h0, req.col_s[3:0]};
                                    len_q    <= 4'h5;
                                end
                            end
                            default: begin
                                seq_q[0] <= `SFZ_OP_COMCFG;
                                seq_q[1] <= `SFZ_COMCFG_ALT;
                                len_q    <= 4'h2;
                            end
                        endcase
                    end
                end
                SFZ_SEND: begin
                    if (!byte_valid || beat) begin
                        if (idx_q == len_q) begin
                            byte_valid <= 1'b0;
                            state_q <= (req_q.cmd == SFZ_CMD_WRCOL) ? SFZ_DATA : SFZ_WAIT;
                        end else begin
                            byte_valid <= 1'b1;
                            byte_dc    <= 1'b0;
                            byte_data  <= seq_q[idx_q];
                            idx_q      <= 4'(idx_q + 4'h1);
                        end
                    end
                end
                SFZ_DATA: begin
                    if (beat) begin
                        byte_valid <= 1'b0;
                    end
                    if (ram_valid && ram_ready) begin
                        byte_valid <= 1'b1;
                        byte_dc    <= 1'b1;
                        byte_data  <= ram_data;
                    end
                    if (ram_cnt_q == ram_len && (beat || !byte_valid)) begin
                        byte_valid <= 1'b0;
                        state_q    <= SFZ_WAIT;
                    end
                end
                SFZ_WAIT: begin
                    req_ready <= 1'b1;
                    state_q   <= SFZ_IDLE;
                end
                default: begin
                    state_q   <= SFZ_IDLE;
                    req_ready <= 1'b1;
                end
            endcase
        end
    end

    // RAM byte intake during a column rewrite, one byte per page
    always_ff @(posedge clk) begin
        if (reset) begin
            ram_cnt_q <= 8'h00;
            ram_ready <= 1'b0;
            ram_done  <= 1'b0;
        end else begin
            ram_done <= 1'b0;
            if (state_q != SFZ_DATA) begin
                ram_cnt_q <= 8'h00;
                ram_ready <= 1'b0;
            end else begin
                ram_ready <= (ram_cnt_q < ram_len) && (!byte_valid || beat)
                             && !(ram_valid && ram_ready);
                if (ram_valid && ram_ready) begin
                    ram_cnt_q <= 8'(ram_cnt_q + 8'h01);
                end
                if (ram_cnt_q == ram_len && (beat || !byte_valid)) begin
                    ram_done <= 1'b1;
                end
            end
        end
    end

    // scroll state tracking; latest setup stands in for all earlier ones
    always_ff @(posedge clk) begin
        if (reset) begin
            scroll_active <= 1'b0;
            setup_ok_q    <= 1'b0;
            need_rewrite  <= 1'b0;
            zoom_ok_q     <= 1'b0;
        end else if (accept && !bad) begin
            case (req.cmd)
                SFZ_CMD_DIAG: begin
                    scroll_active <= 1'b0;
                    setup_ok_q    <= 1'b1;
                end
                SFZ_CMD_STOP: begin
                    if (scroll_active) need_rewrite <= 1'b1;
                    scroll_active <= 1'b0;
                end
                SFZ_CMD_START: scroll_active <= 1'b1;
                SFZ_CMD_WRCOL: need_rewrite <= 1'b0;
                SFZ_CMD_ZOOM:  zoom_ok_q    <= zoom_ok_q;
                SFZ_CMD_CSTEP: need_rewrite <= 1'b0;
                SFZ_CMD_VAREA, SFZ_CMD_FADE: need_rewrite <= need_rewrite;
                default:       zoom_ok_q    <= 1'b1;
            endcase
        end
    end

    // frame gap between content scroll steps
    always_ff @(posedge clk) begin
        if (reset) begin
            gap_q      <= 32'h0000_0000;
            gap_pend_q <= 1'b0;
        end else if (accept && !bad && req.cmd == SFZ_CMD_CSTEP) begin
            gap_q      <= 32'(GAP_CYCLES);
            gap_pend_q <= 1'b1;
        end else if (gap_q != 32'h0000_0000) begin
            gap_q <= gap_q - 32'h0000_0001;
        end else begin
            gap_pend_q <= 1'b0;
        end
    end

    // a step request is never taken inside the frame gap
    chk_gap_holds: assert property (@(posedge clk) disable iff (reset)
        (gap_pend_q && accept && req.cmd == SFZ_CMD_CSTEP) |=> (req_error && req_ready))
        else $error("content step taken inside gap");
    // activation needs a prior setup
    chk_start_setup: assert property (@(posedge clk) disable iff (reset)
        $rose(scroll_active) |-> setup_ok_q)
        else $error("scroll started without setup");
    // stop byte appears within a few cycles of a stop order
    sequence s_stop_taken;
        accept && !bad && req.cmd == SFZ_CMD_STOP;
    endsequence
    chk_stop_byte: assert property (@(posedge clk) disable iff (reset)
        s_stop_taken |-> ##[1:40] (byte_valid && byte_data == `SFZ_OP_SCROLL_OFF))
        else $error("stop byte not sent");
    // diagonal setup leaves scrolling stopped
    chk_diag_stop: assert property (@(posedge clk) disable iff (reset)
        (accept && !bad && req.cmd == SFZ_CMD_DIAG) |=> !scroll_active)
        else $error("setup left scroll running");
    // command bytes carry dc low in the command phase
    chk_cmd_dc: assert property (@(posedge clk) disable iff (reset)
        (byte_valid && state_q == SFZ_SEND) |-> !byte_dc)
        else $error("command byte with dc high");
    // rewrite order is refused while scrolling
    chk_no_ram: assert property (@(posedge clk) disable iff (reset)
        (state_q == SFZ_DATA) |-> !scroll_active)
        else $error("ram access while scrolling");
endmodule : sfz_ctrl

// File: bench/sfz_dev_model.sv
// Purpose: behavioural display device taking command and data bytes
// Assumes: one byte per beat (byte_valid and byte_ready), dc low = command
// Notes:   logs every beat; log, n_log, n_ram and n_shift survive reset for the bench
`timescale 1ns/1ns
module sfz_dev_model (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       slow,
    input  wire logic       byte_valid,
    input  wire logic       byte_dc,
    input  wire logic [7:0] byte_data,
    output logic            byte_ready
);
    logic [8:0] log_q [0:255];
    int         n_log = 0;
    int         n_ram = 0;
    int         n_shift = 0;
    int         n_param;
    logic       setup_q;
    logic       active;

    // slow mode answers every other cycle, so each beat stretches
    always_ff @(posedge clk) begin
        if (reset) byte_ready <= 1'b0;
        else byte_ready <= slow ? ~byte_ready : 1'b1;
    end

    // beat log and opcode decode; parameters are skipped by count
    always_ff @(posedge clk) begin
        if (reset) begin
            n_param <= 0;
            setup_q <= 1'b0;
            active  <= 1'b0;
        end else if (byte_valid && byte_ready) begin
            log_q[n_log] <= {byte_dc, byte_data};
            n_log <= n_log + 1;
            if (byte_dc) n_ram <= n_ram + 1;
            else if (n_param != 0) n_param <= n_param - 1;
            else begin
                case (byte_data)
                    8'h29, 8'h2A: begin
                        n_param <= 7;
                        setup_q <= 1'b1;
                    end
                    8'h26, 8'h27: begin
                        n_param <= 6;
                        setup_q <= 1'b1;
                    end
                    8'h2C, 8'h2D: begin
                        n_param <= 6;
                        n_shift <= n_shift + 1;
                    end
                    8'hA3, 8'h21, 8'h22: n_param <= 2;
                    8'h23, 8'hD6, 8'hDA, 8'h20: n_param <= 1;
                    8'h2E: active <= 1'b0;
                    8'h2F: active <= setup_q;
                    default: n_param <= 0;
                endcase
            end
        end
    end
endmodule : sfz_dev_model

// File: bench/testbench.sv
// Purpose: self-checking bench for the scroll/fade/zoom command sequencer
// Assumes: device model logs byte strings; frame gap shortened to 60 cycles
// Notes:   rows hold orders and expected strings; awkward cases follow them
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module testbench
    import sfz_pkg::*;
;
    logic        clk, reset, req_valid, req_ready, req_error, ram_valid, ram_ready;
    logic        ram_done, byte_valid, byte_dc, byte_ready, scroll_active;
    logic        need_rewrite, slow, nrw;
    logic [7:0]  ram_data, byte_data;
    sfz_req_t    req;
    int          n_fail = 0, n_checks = 0, cycles = 0, ram_cnt = 0, done_cnt = 0, nr = 0;
    sfz_req_t    rq [0:19];
    logic        er [0:19];
    int          nb [0:19], nd [0:19];
    logic [71:0] eb [0:19];

    // gap must outlast a slow 7-byte step plus the bench turnaround
    sfz_ctrl #(.GAP_CYCLES(60), .MUX_RATIO(64)) u_dut (.clk(clk), .reset(reset),
        .req(req), .req_valid(req_valid), .req_ready(req_ready), .req_error(req_error),
        .ram_valid(ram_valid), .ram_data(ram_data), .ram_ready(ram_ready),
        .ram_done(ram_done), .byte_valid(byte_valid), .byte_dc(byte_dc),
        .byte_data(byte_data), .byte_ready(byte_ready), .scroll_active(scroll_active),
        .need_rewrite(need_rewrite));
    sfz_dev_model u_dev (.clk(clk), .reset(reset), .slow(slow), .byte_valid(byte_valid),
        .byte_dc(byte_dc), .byte_data(byte_data), .byte_ready(byte_ready));

    // clock at 50 ns
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ram source counts beats; a hang ends the run through the report
    always @(posedge clk) begin
        cycles++;
        if (ram_valid && ram_ready === 1'b1) ram_cnt++;
        if (ram_done === 1'b1) done_cnt++;
        if (cycles == 20000) begin
            n_fail++;
            summarize();
        end
    end
    always @(negedge clk) ram_data <= ram_cnt[7:0];

    task automatic summarize();
        if (n_fail == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : summarize

    function automatic sfz_req_t mk(sfz_cmd_t c, logic l, logic [2:0] ps, logic [2:0] pe,
        logic [6:0] cs, logic [6:0] ce, logic [2:0] sp, logic h, logic [5:0] v,
        logic [7:0] a, logic vm);
        mk = '{c, l, ps, pe, cs, ce, sp, h, v, a, vm};
    endfunction : mk

    task automatic add(sfz_req_t r, logic e, int n, logic [71:0] b, int d);
        rq[nr] = r;
        er[nr] = e;
        nb[nr] = n;
        eb[nr] = b;
        nd[nr] = d;
        nr++;
    endtask : add

    // one order: hold valid until taken, then compare the logged string
    task automatic order(int i);
        int base, rbase, d0, k;
        logic act0;
        base  = u_dev.n_log;
        rbase = ram_cnt;
        d0    = done_cnt;
        act0  = u_dev.active;
        @(negedge clk);
        req       <= rq[i];
        req_valid <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (req_ready !== 1'b1 && k < 50);
        @(negedge clk);
        req_valid <= 1'b0;
        `CHK(req_error, er[i])
        `CHK(req_ready, er[i])
        k = 0;
        while (req_ready !== 1'b1 && k < 300) begin
            @(negedge clk);
            k++;
        end
        repeat (3) @(negedge clk);
        `CHK(u_dev.n_log - base, nb[i] + nd[i])
        for (k = 0; k < nb[i]; k++)
            `CHK(u_dev.log_q[base + k], {1'b0, eb[i][71 - 8 * k -: 8]})
        for (k = 0; k < nd[i]; k++)
            `CHK(u_dev.log_q[base + nb[i] + k], {1'b1, 8'(rbase + k)})
        `CHK(done_cnt - d0, int'(nd[i] > 0))
        if (!er[i] && rq[i].cmd == SFZ_CMD_STOP && act0) nrw = 1'b1;
        if (!er[i] && (rq[i].cmd == SFZ_CMD_WRCOL || rq[i].cmd == SFZ_CMD_CSTEP)) nrw = 1'b0;
        `CHK(need_rewrite, nrw)
        `CHK(scroll_active, u_dev.active)
    endtask : order

    // reset, table of ordinary orders, then gap boundary and mid-run reset
    initial begin
        reset = 1'b1;
        req = '0;
        req_valid = 1'b0;
        ram_valid = 1'b0;
        slow = 1'b0;
        nrw = 1'b0;
        repeat (5) @(negedge clk);
        `CHK(req_ready, 1'b1)
        `CHK({byte_valid, scroll_active, need_rewrite, req_error, ram_ready}, 5'h00)
        reset = 1'b0;
        ram_valid = 1'b1;
        add(mk(SFZ_CMD_START, 0, 0, 0, 0, 0, 0, 0, 0, 8'h00, 0), 1, 0, '0, 0);
        add(mk(SFZ_CMD_VAREA, 0, 0, 0, 0, 0, 0, 0, 0, 8'h41, 0), 1, 0, '0, 0);
        add(mk(SFZ_CMD_VAREA, 0, 0, 0, 0, 0, 0, 0, 0, 8'h40, 0), 0, 3, 72'hA30040 << 48, 0);
        add(mk(SFZ_CMD_DIAG, 0, 2, 5, 0, 0, 3, 1, 1, 8'h00, 0), 0, 9, 72'h2E2901020305_01007F, 0);
        add(mk(SFZ_CMD_DIAG, 1, 2, 5, 8, 8'h78, 3, 1, 1, 0, 0), 0, 9, 72'h2E2A01020305_010878, 0);
        add(mk(SFZ_CMD_START, 0, 0, 0, 0, 0, 0, 0, 0, 8'h00, 0), 0, 1, 72'h2F << 64, 0);
        add(mk(SFZ_CMD_CSTEP, 1, 2, 5, 8, 8'h78, 0, 0, 0, 0, 0), 1, 0, '0, 0);
        add(mk(SFZ_CMD_WRCOL, 0, 2, 5, 8'h78, 0, 0, 0, 0, 0, 1), 1, 0, '0, 0);
        add(mk(SFZ_CMD_STOP, 0, 0, 0, 0, 0, 0, 0, 0, 8'h00, 0), 0, 1, 72'h2E << 64, 0);
        add(mk(SFZ_CMD_WRCOL, 0, 2, 5, 8'h78, 0, 0, 0, 0, 0, 1), 0, 8, 72'h2001217878220205 << 8, 4);
        add(mk(SFZ_CMD_WRCOL, 0, 2, 2, 8'h78, 0, 0, 0, 0, 0, 0), 0, 5, 72'h2002B21708 << 32, 1);
        add(mk(SFZ_CMD_FADE, 0, 0, 0, 0, 0, 0, 0, 0, 8'h25, 0), 0, 2, 72'h2325 << 56, 0);
        add(mk(SFZ_CMD_ZOOM, 0, 0, 0, 0, 0, 0, 0, 0, 8'h01, 0), 1, 0, '0, 0);
        add(mk(sfz_cmd_t'(4'h8), 0, 0, 0, 0, 0, 0, 0, 0, 8'h00, 0), 0, 2, 72'hDA12 << 56, 0);
        add(mk(SFZ_CMD_ZOOM, 0, 0, 0, 0, 0, 0, 0, 0, 8'h01, 0), 0, 2, 72'hD601 << 56, 0);
        add(mk(SFZ_CMD_CSTEP, 1, 2, 5, 8, 8'h78, 0, 0, 0, 0, 0), 0, 7, 72'h2D000201050878 << 16, 0);
        add(mk(SFZ_CMD_CSTEP, 1, 2, 5, 8, 8'h78, 0, 0, 0, 0, 0), 1, 0, '0, 0);
        for (int i = 0; i < nr; i++) begin
            slow <= i[0];
            order(i);
        end
        repeat (65) @(negedge clk);
        add(mk(SFZ_CMD_CSTEP, 0, 2, 5, 8, 8'h78, 0, 0, 0, 0, 0), 0, 7, 72'h2C000201050878 << 16, 0);
        order(nr - 1);
        order(5);
        reset = 1'b1;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        nrw = 1'b0;
        `CHK({req_ready, scroll_active, byte_valid}, 3'h4)
        order(11);
        summarize();
    end
endmodule : testbench
